// ==== hdl/tccr_consts.svh ====
// Constants for the timer capture/compare register block.
// Assumes inclusion by bare name from every file that needs offsets, fields or reset values.
//
// Functional notes
// RULE_01: Capture/compare value is the match value in compare modes, capture target otherwise.
// RULE_02: With split select clear, all sixteen value bits are software readable and writable.
// RULE_03: In dual 8-bit operation the value register reads zero in its upper byte.
// RULE_04: In dual 8-bit operation software writes to the value upper byte are ignored.
// RULE_05: The low compare byte has no register; it is the value's lower eight bits.
// RULE_06: In dual 8-bit operation the high register holds the high-half capture/compare value.
// RULE_07: High register bits 15 to 8 are reserved, read-only, and reset to zero.
// RULE_08: Six modes decode from split select, counter/timer select and the edge function field.
// RULE_09: 16-bit compare mode honours output enable, polarity, single-shot and clock gating; the code ignores gating while output enable is set.
// RULE_10: 16-bit capture disables the pin output; polarity, single-shot, gating, reload apply.
// RULE_11: Dual 8-bit reload honours output enable and polarity; single-shot acts on high half.
// RULE_12: 8-bit capture mode applies capture controls to the high-byte half only.
// RULE_13: The third instance has no pin and works only as an internal timer.
// RULE_14: Capcmp flag sets on compare match or on an external-edge capture.
// RULE_15: Low compare flag sets only on low byte match; low half never captures.
// RULE_16: Edge field 01 captures rising, 10 falling, 11 both edges.
// RULE_17: A compare value outside the counting range gives no match and no flag.
// RULE_18: A capture beats a software write to the same register in one cycle.

`ifndef TCCR_CONSTS_SVH
`define TCCR_CONSTS_SVH

`define TCCR_ADDR_W 5
`define TCCR_DATA_W 16

`define TCCR_OFS_HIGH0 5'h03
`define TCCR_OFS_HIGH1 5'h07
`define TCCR_OFS_VALUE0 5'h0b
`define TCCR_OFS_VALUE1 5'h0f
`define TCCR_OFS_CTRL 5'h10
`define TCCR_OFS_STATUS 5'h11
`define TCCR_OFS_MASK 5'h12

`define TCCR_RESET_WORD 16'h0000
`define TCCR_RESET_BYTE 8'h00
`define TCCR_RESET_CTRL 9'h000
`define TCCR_RESET_FLAGS 2'h0

`define TCCR_CTRL_W 9
`define TCCR_CTRL_SPLIT 0
`define TCCR_CTRL_CT 1
`define TCCR_CTRL_EDGE_LO 2
`define TCCR_CTRL_EDGE_HI 3
`define TCCR_CTRL_OE 4
`define TCCR_CTRL_POL 5
`define TCCR_CTRL_SS 6
`define TCCR_CTRL_GATE 7
`define TCCR_CTRL_RELOAD 8

`define TCCR_FLAG_W 2
`define TCCR_FLAG_LOW 0
`define TCCR_FLAG_CAPCMP 1

`define TCCR_EDGE_NONE 2'h0
`define TCCR_EDGE_RISE 2'h1
`define TCCR_EDGE_FALL 2'h2
`define TCCR_EDGE_BOTH 2'h3

`endif

// ==== hdl/tccr_pkg.sv ====
// Types shared by the timer capture/compare register block.
// Assumes the constants header is compiled alongside.
package tccr_pkg;

	typedef enum logic [5:0] {
		TCCR_MODE_CMP16 = 6'b00_0001,
		TCCR_MODE_CAP16 = 6'b00_0010,
		TCCR_MODE_CNT16 = 6'b00_0100,
		TCCR_MODE_DUAL8 = 6'b00_1000,
		TCCR_MODE_CAP8 = 6'b01_0000,
		TCCR_MODE_CNT8 = 6'b10_0000
	} tccr_mode_t;

endpackage : tccr_pkg

// ==== hdl/tccr_edge_detect.sv ====
// Edge detector for the timer pin.
// Assumes the pin input is already synchronous to clk.
`timescale 1ns/10ps
`include "tccr_consts.svh"

module tccr_edge_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic pin_in,
	input wire logic [1:0] edge_function_field,
	output logic edge_rise,
	output logic edge_fall,
	output logic edge_hit
);

	logic pin_prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev <= 1'b0;
		end else if (ce) begin
			pin_prev <= pin_in;
		end
	end

	assign edge_rise = pin_in & ~pin_prev;
	assign edge_fall = ~pin_in & pin_prev;

	// Both-edge selection is the OR of the two single-edge cases.
	always_comb begin
		case (edge_function_field)
			`TCCR_EDGE_RISE: edge_hit = edge_rise; // RULE_16
			`TCCR_EDGE_FALL: edge_hit = edge_fall; // RULE_16
			`TCCR_EDGE_BOTH: edge_hit = edge_rise | edge_fall; // RULE_16
			default: edge_hit = 1'b0;
		endcase
	end

endmodule // tccr_edge_detect

// ==== hdl/tccr_capcmp.sv ====
// One timer instance's capture/compare storage, mode decode, pin control and flags.
// Assumes the timer core outside supplies the count, reload values, count step and overflow pulses,
// all synchronous to clk; the register port is a plain one-cycle strobe bus.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "tccr_consts.svh"

module tccr_capcmp #(
	parameter bit HAS_PIN = 1'b1,
	parameter logic [`TCCR_ADDR_W-1:0] HIGH_ADDR = `TCCR_OFS_HIGH0,
	parameter logic [`TCCR_ADDR_W-1:0] VALUE_ADDR = `TCCR_OFS_VALUE0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [`TCCR_ADDR_W-1:0] reg_addr,
	input wire logic [`TCCR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`TCCR_DATA_W-1:0] reg_rdata,
	input wire logic [15:0] count_value,
	input wire logic [7:0] count_high_byte,
	input wire logic [15:0] reload_value,
	input wire logic [7:0] reload_high,
	input wire logic count_step,
	input wire logic overflow,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	output logic timer_gate,
	output logic single_shot_run,
	output logic capture_pulse,
	output logic reload_pulse,
	output logic count_edge,
	output logic irq
);

	// Compare only counts once the count has climbed to the value; below the reload floor
	// the count never gets there, so such a value must never signal a match.
	function automatic logic in_range_match(
		input logic [15:0] count,
		input logic [15:0] match,
		input logic [15:0] floor
	);
		in_range_match = (match >= floor) && (count == match);
	endfunction

	function automatic tccr_pkg::tccr_mode_t decode_mode(
		input logic split,
		input logic ct,
		input logic [1:0] edge_sel
	);
		if (edge_sel == `TCCR_EDGE_NONE) begin
			decode_mode = split ? tccr_pkg::TCCR_MODE_DUAL8 : tccr_pkg::TCCR_MODE_CMP16;
		end else if (ct) begin
			decode_mode = split ? tccr_pkg::TCCR_MODE_CNT8 : tccr_pkg::TCCR_MODE_CNT16;
		end else begin
			decode_mode = split ? tccr_pkg::TCCR_MODE_CAP8 : tccr_pkg::TCCR_MODE_CAP16;
		end
	endfunction

	logic [`TCCR_CTRL_W-1:0] ctrl;
	logic [15:0] capcmp_value;
	logic [7:0] capcmp_high;
	logic [`TCCR_FLAG_W-1:0] status;
	logic [`TCCR_FLAG_W-1:0] mask;
	logic [`TCCR_FLAG_W-1:0] flag_set;
	logic [`TCCR_FLAG_W-1:0] next_status;
	logic [`TCCR_DATA_W-1:0] next_rdata;
	tccr_pkg::tccr_mode_t mode;

	logic split_byte_select;
	logic counter_timer_select;
	logic [1:0] edge_function_field;
	logic pin_output_enable;
	logic pin_polarity;
	logic single_shot;
	logic clock_gate_enable;
	logic capture_reload_enable;

	logic is_compare;
	logic is_capture;
	logic is_counter;
	logic oe_active;
	logic oe_prev;
	logic pol_latched;
	logic wave;
	logic toggle_due;
	logic pin_seen;
	logic edge_rise;
	logic edge_fall;
	logic edge_hit;
	logic capture_evt;
	logic capture16;
	logic capture8;
	logic match16;
	logic match_high;
	logic match_low;
	logic reload_gated_edge;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_value;
	logic wr_high;
	logic rd_status;

	assign split_byte_select = ctrl[`TCCR_CTRL_SPLIT];
	assign counter_timer_select = ctrl[`TCCR_CTRL_CT];
	assign edge_function_field = ctrl[`TCCR_CTRL_EDGE_HI:`TCCR_CTRL_EDGE_LO];
	assign pin_output_enable = ctrl[`TCCR_CTRL_OE];
	assign pin_polarity = ctrl[`TCCR_CTRL_POL];
	assign single_shot = ctrl[`TCCR_CTRL_SS];
	assign clock_gate_enable = ctrl[`TCCR_CTRL_GATE];
	assign capture_reload_enable = ctrl[`TCCR_CTRL_RELOAD];

	assign wr_ctrl = reg_wr && (reg_addr == `TCCR_OFS_CTRL);
	assign wr_mask = reg_wr && (reg_addr == `TCCR_OFS_MASK);
	assign wr_value = reg_wr && (reg_addr == VALUE_ADDR);
	assign wr_high = reg_wr && (reg_addr == HIGH_ADDR);
	assign rd_status = reg_rd && (reg_addr == `TCCR_OFS_STATUS);

	assign mode = decode_mode(split_byte_select, counter_timer_select, edge_function_field); // RULE_08

	always_comb begin
		case (mode)
			tccr_pkg::TCCR_MODE_CMP16,
			tccr_pkg::TCCR_MODE_DUAL8: begin
				is_compare = 1'b1;
				is_capture = 1'b0;
				is_counter = 1'b0;
			end
			tccr_pkg::TCCR_MODE_CAP16,
			tccr_pkg::TCCR_MODE_CAP8: begin
				is_compare = 1'b0;
				is_capture = 1'b1;
				is_counter = 1'b0;
			end
			tccr_pkg::TCCR_MODE_CNT16,
			tccr_pkg::TCCR_MODE_CNT8: begin
				is_compare = 1'b0;
				is_capture = 1'b0;
				is_counter = 1'b1;
			end
			default: begin
				is_compare = 1'b0;
				is_capture = 1'b0;
				is_counter = 1'b0;
			end
		endcase
	end

	// Without a pin the instance sees a quiet input and never drives out.
	assign pin_seen = HAS_PIN ? pin_in : 1'b0; // RULE_13
	assign oe_active = HAS_PIN && is_compare && pin_output_enable; // RULE_09 RULE_10 RULE_11 RULE_12 RULE_13

	tccr_edge_detect u_edge (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pin_in(pin_seen),
		.edge_function_field(edge_function_field),
		.edge_rise(edge_rise),
		.edge_fall(edge_fall),
		.edge_hit(edge_hit)
	);

	// In split capture only the high half captures; the low half stays a plain timer.
	assign capture_evt = is_capture && edge_hit;
	assign capture16 = capture_evt && (mode == tccr_pkg::TCCR_MODE_CAP16); // RULE_01 RULE_10
	assign capture8 = capture_evt && (mode == tccr_pkg::TCCR_MODE_CAP8); // RULE_06 RULE_12 RULE_15
	assign capture_pulse = capture_evt;
	assign count_edge = is_counter && edge_hit;

	// With both edges and gating, the polarity picks the edge that captures without reloading.
	assign reload_gated_edge = clock_gate_enable && (edge_function_field == `TCCR_EDGE_BOTH)
		&& (pin_polarity ? edge_rise : edge_fall);
	assign reload_pulse = capture_evt && capture_reload_enable && !reload_gated_edge; // RULE_10 RULE_12

	// Gating is ignored while the pin drives out, and in both-edge capture it gates reload instead.
	assign timer_gate = HAS_PIN && clock_gate_enable && !oe_active && !is_counter
		&& (mode != tccr_pkg::TCCR_MODE_DUAL8)
		&& !(is_capture && (edge_function_field == `TCCR_EDGE_BOTH))
		&& (pin_seen == pin_polarity); // RULE_09 RULE_10 RULE_12

	assign single_shot_run = single_shot; // RULE_09 RULE_11

	assign match16 = (mode == tccr_pkg::TCCR_MODE_CMP16) && count_step
		&& in_range_match(count_value, capcmp_value, reload_value); // RULE_01 RULE_17
	assign match_high = (mode == tccr_pkg::TCCR_MODE_DUAL8) && count_step
		&& in_range_match({8'h00, count_high_byte}, {8'h00, capcmp_high}, {8'h00, reload_high}); // RULE_06 RULE_17
	assign match_low = split_byte_select && !is_counter && count_step
		&& in_range_match({8'h00, count_value[7:0]}, {8'h00, capcmp_value[7:0]},
			{8'h00, reload_value[7:0]}); // RULE_05 RULE_15 RULE_17

	assign flag_set[`TCCR_FLAG_CAPCMP] = match16 || match_high || capture_evt; // RULE_14
	assign flag_set[`TCCR_FLAG_LOW] = match_low; // RULE_15

	// A new event in the very cycle of the clearing read survives it.
	assign next_status = (rd_status ? `TCCR_RESET_FLAGS : status) | flag_set;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= `TCCR_RESET_FLAGS;
		end else if (ce) begin
			status <= next_status;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= `TCCR_RESET_FLAGS;
		end else if (ce && wr_mask) begin
			mask <= reg_wdata[`TCCR_FLAG_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(next_status & mask);
		end
	end

	// Single-shot self-clears at the overflow/reload in compare modes and after the one capture
	// in capture modes; a software write in the same cycle takes priority.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `TCCR_RESET_CTRL;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl <= reg_wdata[`TCCR_CTRL_W-1:0];
			end else if ((is_compare && overflow) || capture_evt) begin
				ctrl[`TCCR_CTRL_SS] <= 1'b0; // RULE_10 RULE_12
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capcmp_value <= `TCCR_RESET_WORD;
		end else if (ce) begin
			if (capture16) begin
				capcmp_value <= count_value; // RULE_01 RULE_18
			end else if (wr_value) begin
				if (split_byte_select) begin
					capcmp_value[7:0] <= reg_wdata[7:0]; // RULE_04 RULE_05
				end else begin
					capcmp_value <= reg_wdata; // RULE_02
				end
			end
		end
	end

	// Only eight bits are stored, so the reserved upper bits cannot be written.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capcmp_high <= `TCCR_RESET_BYTE;
		end else if (ce) begin
			if (capture8) begin
				capcmp_high <= count_high_byte; // RULE_06 RULE_18
			end else if (wr_high) begin
				capcmp_high <= reg_wdata[7:0]; // RULE_06 RULE_07
			end
		end
	end

	// The wave bit toggles two clocks after a match or overflow, the pin one clock later; a match at the overflow
	// point falls in the same cycle and so gives only one toggle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_due <= 1'b0;
			wave <= 1'b0;
		end else if (ce) begin
			toggle_due <= is_compare && (match16 || match_high || overflow);
			wave <= wave ^ toggle_due;
		end
	end

	// Polarity reaches the pin only when the output enable rises, so a change mid-waveform
	// cannot glitch the pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_prev <= 1'b0;
			pol_latched <= 1'b0;
		end else if (ce) begin
			oe_prev <= oe_active;
			if (oe_active && !oe_prev) begin
				pol_latched <= pin_polarity; // RULE_09 RULE_11
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
		end else if (ce) begin
			pin_out <= oe_active && (wave ^ pol_latched);
			pin_oe_n <= !oe_active; // RULE_10 RULE_13
		end
	end

	always_comb begin
		next_rdata = `TCCR_RESET_WORD;
		if (reg_addr == VALUE_ADDR) begin
			next_rdata = split_byte_select ? {8'h00, capcmp_value[7:0]} : capcmp_value; // RULE_02 RULE_03
		end else if (reg_addr == HIGH_ADDR) begin
			next_rdata = {8'h00, capcmp_high}; // RULE_07
		end else if (reg_addr == `TCCR_OFS_CTRL) begin
			next_rdata = {7'h00, ctrl};
		end else if (reg_addr == `TCCR_OFS_STATUS) begin
			next_rdata = {14'h0000, status};
		end else if (reg_addr == `TCCR_OFS_MASK) begin
			next_rdata = {14'h0000, mask};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `TCCR_RESET_WORD;
		end else if (ce) begin
			reg_rdata <= reg_rd ? next_rdata : `TCCR_RESET_WORD;
		end
	end

endmodule // tccr_capcmp

// ==== tb/tccr_capcmp_chk.sv ====
// Concurrent checks for one capture/compare instance.
// Sees only the module ports; control and mask are mirrored from bus writes.
`timescale 1ns/10ps
`include "tccr_consts.svh"
module tccr_capcmp_chk #(
	parameter bit HAS_PIN = 1'b1,
	parameter logic [4:0] HIGH_ADDR = `TCCR_OFS_HIGH0,
	parameter logic [4:0] VALUE_ADDR = `TCCR_OFS_VALUE0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] count_value,
	input wire logic pin_in,
	input wire logic pin_oe_n,
	input wire logic capture_pulse,
	input wire logic irq
);
	logic [8:0] ctl;
	logic mask1;
	logic pin_q;
	logic cap;
	logic hit;
	// Only bus writes reach the mirror, so it misses the hardware single-shot clear of the control register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= `TCCR_RESET_CTRL;
			mask1 <= 1'b0;
		end else if (ce && reg_wr && reg_addr == `TCCR_OFS_CTRL) begin
			ctl <= reg_wdata[8:0];
		end else if (ce && reg_wr && reg_addr == `TCCR_OFS_MASK) begin
			mask1 <= reg_wdata[`TCCR_FLAG_CAPCMP];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pin_q <= 1'b0;
		else if (ce)
			pin_q <= pin_in;
	end
	assign cap = !ctl[`TCCR_CTRL_CT] && ctl[3:2] != 2'h0;
	assign hit = (ctl[2] && !pin_q && pin_in) || (ctl[3] && pin_q && !pin_in);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		ce && !reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_high_rsvd;
		ce && reg_rd && reg_addr == HIGH_ADDR |=> reg_rdata[15:8] == 8'h00;
	endproperty
	a_high_rsvd: assert property (p_high_rsvd) else $error("high register upper byte set");
	property p_split_rd;
		ce && reg_rd && reg_addr == VALUE_ADDR && ctl[`TCCR_CTRL_SPLIT] |=> reg_rdata[15:8] == 8'h00;
	endproperty
	a_split_rd: assert property (p_split_rd) else $error("split value upper byte set");
	property p_cap_oe;
		(ce && cap) [*3] |-> pin_oe_n;
	endproperty
	a_cap_oe: assert property (p_cap_oe) else $error("pin driven in capture");
	property p_cmp_oe;
		(ce && HAS_PIN && ctl[4:0] == 5'h10) [*3] |-> !pin_oe_n;
	endproperty
	a_cmp_oe: assert property (p_cmp_oe) else $error("pin not driven in compare");
	property p_cap_edge;
		ce && cap && HAS_PIN && ctl[7:6] == 2'h0 |-> capture_pulse == hit;
	endproperty
	a_cap_edge: assert property (p_cap_edge) else $error("capture edge wrong");
	property p_cap_irq;
		ce && capture_pulse && mask1 && !(reg_wr && reg_addr == `TCCR_OFS_MASK) |=> irq;
	endproperty
	a_cap_irq: assert property (p_cap_irq) else $error("capture raised no interrupt");
	property p_cap_wins;
		(ce && capture_pulse && !ctl[0] && reg_wr && reg_addr == VALUE_ADDR) ##1
			(ce && reg_rd && reg_addr == VALUE_ADDR) |=> reg_rdata == $past(count_value, 2);
	endproperty
	a_cap_wins: assert property (p_cap_wins) else $error("write beat capture");
endmodule // tccr_capcmp_chk

bind tccr_capcmp tccr_capcmp_chk #(.HAS_PIN(HAS_PIN), .HIGH_ADDR(HIGH_ADDR), .VALUE_ADDR(VALUE_ADDR)) chk (
	.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_value(count_value), .pin_in(pin_in),
	.pin_oe_n(pin_oe_n), .capture_pulse(capture_pulse), .irq(irq)
);

// ==== tb/tccr_pin_model.sv ====
// External edge or gate source on the timer pin.
// Assumes the bench resolves the shared wire from the device enable.
`timescale 1ns/10ps
module tccr_pin_model #(
	parameter int LAG = 0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic lvl,
	output logic pin = 1'b0
);
	// A slow source keeps its old level for LAG extra cycles.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin <= 1'b0;
		end else if (req) begin
			repeat (LAG) @(posedge clk);
			pin <= lvl;
		end
	end
endmodule // tccr_pin_model

// ==== tb/timer_capture_compare_regs_tb.sv ====
// Self-checking bench for one capture/compare instance against a register model.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`include "tccr_consts.svh"
module timer_capture_compare_regs_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic count_step = 1'b0;
	logic pin_req = 1'b0;
	logic pin_lvl = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] count_value = 16'h0000;
	logic [15:0] reload_value = 16'h0000;
	logic [7:0] count_high_byte = 8'h00;
	logic [7:0] reload_high = 8'h00;
	logic [15:0] rdata;
	logic pin_drv, pin_in, pin_out, pin_oe_n, cap_p, cnt_p, irq;
	logic [4:0] regs [6] = '{`TCCR_OFS_HIGH0, `TCCR_OFS_VALUE0, `TCCR_OFS_CTRL, `TCCR_OFS_STATUS, `TCCR_OFS_MASK, 5'h01};
	int errors = 0;
	int cmp_count = 0;
	int m_val = 0, m_high = 0, m_ctrl = 0, m_stat = 0, m_mask = 0, v, e, s;

	always #5 clk = ~clk;
	// The source only owns the wire while the device output is off.
	assign pin_in = pin_oe_n ? pin_drv : pin_out;

	tccr_pin_model src (.clk(clk), .rst_n(rst_n), .req(pin_req), .lvl(pin_lvl), .pin(pin_drv));
	tccr_capcmp uut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata), .count_value(count_value), .count_high_byte(count_high_byte),
		.reload_value(reload_value), .reload_high(reload_high), .count_step(count_step), .overflow(1'b0),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_gate(), .single_shot_run(),
		.capture_pulse(cap_p), .reload_pulse(), .count_edge(cnt_p), .irq(irq)
	);

	task automatic finish_test;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	function automatic int exp_rd(input logic [4:0] a);
		case (a)
			`TCCR_OFS_HIGH0: return m_high;
			`TCCR_OFS_VALUE0: return m_ctrl[0] ? m_val & 16'h00ff : m_val;
			`TCCR_OFS_CTRL: return m_ctrl;
			`TCCR_OFS_STATUS: return m_stat;
			`TCCR_OFS_MASK: return m_mask;
			default: return 0;
		endcase
	endfunction

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		if (a == `TCCR_OFS_HIGH0)
			m_high = d[7:0];
		if (a == `TCCR_OFS_VALUE0)
			m_val = m_ctrl[0] ? (m_val & 16'hff00) | d[7:0] : d;
		if (a == `TCCR_OFS_CTRL)
			m_ctrl = d[8:0];
		if (a == `TCCR_OFS_MASK)
			m_mask = d[1:0];
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(rdata, 16'(exp_rd(a)));
		if (a == `TCCR_OFS_STATUS)
			m_stat = 0;
		chk({15'h0000, irq}, 16'(|(m_stat & m_mask)));
	endtask

	task automatic pin_set(input logic l, input bit hit);
		@(posedge clk);
		pin_req <= 1'b1;
		pin_lvl <= l;
		@(posedge clk);
		pin_req <= 1'b0;
		count_value <= 16'($urandom);
		count_high_byte <= 8'($urandom);
		if (hit) begin
			reg_addr <= `TCCR_OFS_VALUE0;
			reg_wdata <= 16'h1234;
			reg_wr <= 1'b1;
		end
		#1;
		v = (m_ctrl[2] && l) || (m_ctrl[3] && !l);
		chk({15'h0000, cap_p}, 16'(v && !m_ctrl[1]));
		chk({15'h0000, cnt_p}, 16'(v && m_ctrl[1]));
		chk({15'h0000, pin_oe_n}, 16'h0001);
		if (v && !m_ctrl[1]) begin
			if (m_ctrl[0])
				m_high = count_high_byte;
			else
				m_val = count_value;
			m_stat = m_stat | 2;
		end
		if (hit) begin
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1;
			chk(rdata, 16'(m_val));
		end
	endtask

	task automatic cmp_step(input logic [15:0] cv, input logic [7:0] hb, input logic [15:0] rl);
		@(posedge clk);
		count_value <= cv;
		count_high_byte <= hb;
		reload_value <= rl;
		count_step <= 1'b1;
		@(posedge clk);
		count_step <= 1'b0;
		if (!m_ctrl[0] && cv == m_val && m_val >= rl)
			m_stat = m_stat | 2;
		if (m_ctrl[0] && cv[7:0] == m_val[7:0] && m_val[7:0] >= rl[7:0])
			m_stat = m_stat | 1;
		if (m_ctrl[0] && hb == m_high && m_high >= reload_high)
			m_stat = m_stat | 2;
		rd(`TCCR_OFS_STATUS);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("BAD %0t run too long", $time);
		finish_test();
	end

	initial begin
		void'($urandom(93));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (regs[i]) rd(regs[i]);
		wr(5'h01, 16'hffff);
		rd(5'h01);
		repeat (4) begin
			wr(`TCCR_OFS_VALUE0, 16'($urandom));
			rd(`TCCR_OFS_VALUE0);
		end
		wr(`TCCR_OFS_HIGH0, 16'hffff);
		rd(`TCCR_OFS_HIGH0);
		wr(`TCCR_OFS_CTRL, 16'h0001);
		wr(`TCCR_OFS_VALUE0, 16'hbeef);
		rd(`TCCR_OFS_VALUE0);
		wr(`TCCR_OFS_CTRL, 16'h0000);
		rd(`TCCR_OFS_VALUE0);
		// Every split and counter select against each nonzero edge code; only the unsplit capture cases are unmasked.
		for (s = 0; s < 4; s++)
			for (e = 1; e < 4; e++) begin
				wr(`TCCR_OFS_CTRL, 16'(s + e * 4));
				wr(`TCCR_OFS_MASK, 16'(s == 0 ? 2 : 0));
				pin_set(1'b1, s == 0 && e == 1);
				pin_set(1'b0, 1'b0);
				rd(`TCCR_OFS_VALUE0);
				rd(`TCCR_OFS_HIGH0);
				rd(`TCCR_OFS_STATUS);
			end
		wr(`TCCR_OFS_CTRL, 16'h0010);
		wr(`TCCR_OFS_MASK, 16'h0003);
		for (s = 0; s < 4; s++) begin
			v = $urandom_range(16'hfffe, 16'h0001);
			wr(`TCCR_OFS_VALUE0, 16'(v));
			cmp_step(16'(v), 8'h00, 16'(s[0] ? v + 1 : v - 1));
			chk({15'h0000, pin_oe_n}, 16'h0000);
		end
		wr(`TCCR_OFS_CTRL, 16'h0001);
		wr(`TCCR_OFS_VALUE0, 16'h0033);
		wr(`TCCR_OFS_HIGH0, 16'h0040);
		cmp_step(16'h0033, 8'h40, 16'h0010);
		cmp_step(16'h0033, 8'h41, 16'h0040);
		finish_test();
	end
endmodule // timer_capture_compare_regs_tb
